// *** core/dps_sequencer.sv ***
// drive profile sequencer: runs one of two stored step profiles from input terminals
// assumes terminal inputs synchronous to CORE_CLK and a ramp generator outside
// Notes on behaviour
// - codes 41 and 42 start profile one/two
// - code 43 hands control to normal sources
// - gated type: go-step while stopped advances
// - free-run type: hold-step freezes current step
// - code 20 output pulses on step change
// - code 21 output pulses 100 ms at last step
// - free-run type runs all steps unattended
// - gated type: advance per go-step while start held
// - second start within window means simultaneous
// - only steps up to step count run
// - each step has own frequency per profile
// - ramp time sets travel to target frequency
// - hold target for dwell time, then move
// - each step applies its own direction
// - step count limited to one through eight
// - window 0.02 to 2.00 s, default 0.10
`timescale 1ns/1ps
`include "dps_cfg.svh"

module dps_sequencer
  import dps_pkg::*;
#(
  parameter int NIN         = 8,
  parameter int NOUT        = 3,
  parameter int TICK_CYCLES = `DPS_TICK_CYCLES
) (
  input  wire logic              CORE_CLK,
  input  wire logic              NRST,
  input  wire logic [NIN-1:0]    PIN_IN,
  input  wire logic [NIN*8-1:0]  INPUT_PIN_FUNCTION,
  input  wire logic [NOUT*8-1:0] OUTPUT_PIN_FUNCTION,
  input  wire logic              ADV_TYPE,
  input  wire logic [7:0]        COINC_WINDOW,
  input  wire logic [3:0]        STEP_COUNT1,
  input  wire logic [3:0]        STEP_COUNT2,
  input  wire logic              MOTOR_STOPPED,
  input  wire logic              STEP_WR_EN,
  input  wire logic              STEP_WR_PROFILE,
  input  wire logic [2:0]        STEP_WR_INDEX,
  input  wire logic [15:0]       STEP_WR_FREQ,
  input  wire logic [12:0]       STEP_WR_RAMP,
  input  wire logic [12:0]       STEP_WR_DWELL,
  input  wire logic              STEP_WR_FWD,
  output logic                   RUN_CMD,
  output logic [15:0]            FREQ_REF,
  output logic [12:0]            RAMP_TIME,
  output logic                   DIR_FWD,
  output logic                   USE_MANUAL,
  output logic                   SEQ_ACTIVE,
  output logic                   ACTIVE_PROFILE,
  output logic [2:0]             STEP_NUM,
  output logic                   START_CONFLICT,
  output logic [NOUT-1:0]        OUT_PIN
);

  // ==========================================
  // terminal decode
  logic [NIN-1:0]  hit_seq1, hit_seq2, hit_man, hit_go, hit_hold;
  logic [NOUT-1:0] is_step_out, is_seq_out;

  for (genvar i = 0; i < NIN; i++) begin : g_in
    // each terminal matched against its configured function
    assign hit_seq1[i] = PIN_IN[i] && (INPUT_PIN_FUNCTION[i*8 +: 8] == `DPS_FN_SEQ1);
    assign hit_seq2[i] = PIN_IN[i] && (INPUT_PIN_FUNCTION[i*8 +: 8] == `DPS_FN_SEQ2);
    assign hit_man[i]  = PIN_IN[i] && (INPUT_PIN_FUNCTION[i*8 +: 8] == `DPS_FN_MANUAL);
    assign hit_go[i]   = PIN_IN[i] && (INPUT_PIN_FUNCTION[i*8 +: 8] == `DPS_FN_GO_STEP);
    assign hit_hold[i] = PIN_IN[i] && (INPUT_PIN_FUNCTION[i*8 +: 8] == `DPS_FN_HOLD_STEP);
  end

  logic seq1, seq2, manual, go, hold;
  assign seq1   = |hit_seq1;
  assign seq2   = |hit_seq2;
  assign manual = |hit_man;
  assign go     = |hit_go;
  assign hold   = |hit_hold;

  // ==========================================
  // clamped settings
  logic [3:0] cnt1, cnt2, cnt_sel;
  logic [7:0] win;
  always_comb begin
    cnt1 = STEP_COUNT1;
    if (STEP_COUNT1 < `DPS_STEPS_MIN) cnt1 = `DPS_STEPS_MIN;
    if (STEP_COUNT1 > `DPS_STEPS_MAX) cnt1 = `DPS_STEPS_MAX;
    cnt2 = STEP_COUNT2;
    if (STEP_COUNT2 < `DPS_STEPS_MIN) cnt2 = `DPS_STEPS_MIN;
    if (STEP_COUNT2 > `DPS_STEPS_MAX) cnt2 = `DPS_STEPS_MAX;
    win = COINC_WINDOW;
    if (COINC_WINDOW < `DPS_WIN_MIN) win = `DPS_WIN_MIN;
    if (COINC_WINDOW > `DPS_WIN_MAX) win = `DPS_WIN_MAX;
  end

  // ==========================================
  // timebase: 10 ms tick and 100 ms tick
  logic [$clog2(TICK_CYCLES+1)-1:0] cyc_q;
  logic [3:0] deci_q;
  logic       tick, deci;
  assign tick = (cyc_q == ($bits(cyc_q))'(TICK_CYCLES - 1));
  assign deci = tick && (deci_q == 4'(`DPS_DECI_TICKS - 1));

  // free-running prescaler, restarts only at reset
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      cyc_q  <= '0;
      deci_q <= 4'h0;
    end else begin
      cyc_q <= tick ? '0 : cyc_q + 1'b1;
      if (tick) begin
        deci_q <= deci ? 4'h0 : deci_q + 4'h1;
      end
    end
  end

  // ==========================================
  // step store
  logic        prof_q;
  logic [2:0]  step_q;
  logic [42:0] rd_data;

  dps_step_mem #(
    .WIDTH (43),
    .AW    (4)
  ) u_mem (
    .CORE_CLK (CORE_CLK),
    .WR_EN    (STEP_WR_EN),
    .WR_ADDR  ({STEP_WR_PROFILE, STEP_WR_INDEX}),
    .WR_DATA  ({STEP_WR_FREQ, STEP_WR_RAMP, STEP_WR_DWELL, STEP_WR_FWD}),
    .RD_ADDR  ({prof_q, step_q}),
    .RD_DATA  (rd_data)
  );

  // ==========================================
  // sequencer state
  dps_state_t state_q;
  logic [7:0]  win_q;
  logic [12:0] timer_q;
  logic [12:0] dwell_q;
  logic        go_q;
  logic        last_step, go_edge, start_edge, seq1_q, seq2_q, advance;

  assign cnt_sel    = prof_q ? cnt2 : cnt1;
  assign last_step  = ({1'b0, step_q} == cnt_sel - 4'h1);
  assign go_edge    = go && !go_q;
  assign start_edge = (seq1 && !seq1_q) || (seq2 && !seq2_q);
  // a step change: leaving a finished step for a further one
  assign advance    = ((state_q == DPS_DWELL) && (ADV_TYPE == DPS_FREE_RUN) && !hold
                       && deci && (timer_q + 13'h1 >= dwell_q) && !last_step)
                   || ((state_q == DPS_WAITGO) && go_edge && MOTOR_STOPPED && (seq1 || seq2));

  // input edge history
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      go_q   <= 1'b0;
      seq1_q <= 1'b0;
      seq2_q <= 1'b0;
    end else begin
      go_q   <= go;
      seq1_q <= seq1;
      seq2_q <= seq2;
    end
  end

  // main step machine; manual selection always wins and drops the profile
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      state_q        <= DPS_IDLE;
      prof_q         <= 1'b0;
      step_q         <= 3'h0;
      win_q          <= 8'h00;
      timer_q        <= 13'h0000;
      START_CONFLICT <= 1'b0;
    end else if (manual) begin
      state_q <= DPS_IDLE;
    end else begin
      unique case (state_q)
        DPS_IDLE: begin
          win_q   <= 8'h00;
          if (start_edge) begin
            state_q <= DPS_ARM;
          end
        end
        DPS_ARM: begin
          // wait out the window so a late partner input is seen
          if (tick) win_q <= win_q + 8'h01;
          if (!seq1 && !seq2) begin
            state_q <= DPS_IDLE;
          end else if (tick && (win_q + 8'h01 >= win)) begin
            START_CONFLICT <= seq1 && seq2;
            if (seq1 && seq2) begin
              state_q <= DPS_IDLE;
            end else begin
              prof_q  <= seq2;
              step_q  <= 3'h0;
              state_q <= DPS_LOAD;
            end
          end
        end
        DPS_LOAD:  state_q <= DPS_FETCH;
        DPS_FETCH: begin
          timer_q <= 13'h0000;
          state_q <= DPS_RAMP;
        end
        DPS_RAMP: begin
          if (deci) timer_q <= timer_q + 13'h1;
          if (deci && (timer_q + 13'h1 >= RAMP_TIME)) begin
            timer_q <= 13'h0000;
            state_q <= DPS_DWELL;
          end
        end
        DPS_DWELL: begin
          if (deci && !(hold && ADV_TYPE == DPS_FREE_RUN)) begin
            timer_q <= timer_q + 13'h1;
          end
          if (advance) begin
            step_q  <= step_q + 3'h1;
            state_q <= DPS_LOAD;
          end else if (deci && (timer_q + 13'h1 >= dwell_q)
                       && !(hold && ADV_TYPE == DPS_FREE_RUN)) begin
            if (last_step) begin
              state_q <= DPS_IDLE;
            end else if (ADV_TYPE == DPS_GATED) begin
              state_q <= DPS_WAITGO;
            end
          end
        end
        DPS_WAITGO: begin
          if (!seq1 && !seq2) begin
            state_q <= DPS_IDLE;
          end else if (advance) begin
            step_q  <= step_q + 3'h1;
            state_q <= DPS_LOAD;
          end
        end
      endcase
    end
  end

  // step outputs latched once the stored word is out
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      FREQ_REF  <= 16'h0000;
      RAMP_TIME <= 13'h0001;
      dwell_q   <= 13'h0001;
      DIR_FWD   <= 1'b1;
    end else if (state_q == DPS_FETCH) begin
      FREQ_REF  <= rd_data[42:27];
      RAMP_TIME <= rd_data[26:14];
      dwell_q   <= rd_data[13:1];
      DIR_FWD   <= rd_data[0];
    end
  end

  // ==========================================
  // status levels
  logic running;
  assign running = (state_q == DPS_LOAD) || (state_q == DPS_FETCH)
                || (state_q == DPS_RAMP) || (state_q == DPS_DWELL);

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      RUN_CMD        <= 1'b0;
      USE_MANUAL     <= 1'b0;
      SEQ_ACTIVE     <= 1'b0;
      ACTIVE_PROFILE <= 1'b0;
      STEP_NUM       <= 3'h0;
    end else begin
      RUN_CMD        <= running && !manual; // stopped while waiting for go
      USE_MANUAL     <= manual;
      SEQ_ACTIVE     <= (running || state_q == DPS_WAITGO) && !manual;
      ACTIVE_PROFILE <= prof_q;
      STEP_NUM       <= step_q;
    end
  end

  // ==========================================
  // pulse outputs, both stretched to 100 ms
  logic [3:0] step_pls_q, seq_pls_q;
  logic       enter_last;
  assign enter_last = (state_q == DPS_FETCH) && last_step;

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      step_pls_q <= 4'h0;
      seq_pls_q  <= 4'h0;
    end else begin
      // a new trigger restarts the stretch rather than being lost
      if (advance) begin
        step_pls_q <= 4'(`DPS_PULSE_TICKS);
      end else if (tick && step_pls_q != 4'h0) begin
        step_pls_q <= step_pls_q - 4'h1;
      end
      if (enter_last) begin
        seq_pls_q <= 4'(`DPS_PULSE_TICKS);
      end else if (tick && seq_pls_q != 4'h0) begin
        seq_pls_q <= seq_pls_q - 4'h1;
      end
    end
  end

  for (genvar j = 0; j < NOUT; j++) begin : g_out
    assign is_step_out[j] = (OUTPUT_PIN_FUNCTION[j*8 +: 8] == `DPS_FN_STEP_PULSE);
    assign is_seq_out[j]  = (OUTPUT_PIN_FUNCTION[j*8 +: 8] == `DPS_FN_SEQ_PULSE);
    // output terminal driven from the stretched pulse it is set for
    always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
        OUT_PIN[j] <= 1'b0;
      end else begin
        OUT_PIN[j] <= (is_step_out[j] && step_pls_q != 4'h0)
                   || (is_seq_out[j] && seq_pls_q != 4'h0);
      end
    end
  end

endmodule : dps_sequencer

// *** core/dps_cfg.svh ***
// constants of the drive profile sequencer: terminal function codes, limits, timing
// assumes inclusion by bare name from packages and modules of this block
`ifndef DPS_CFG_SVH
`define DPS_CFG_SVH

// ==========================================
// terminal function codes
`define DPS_FN_SEQ1       8'h29
`define DPS_FN_SEQ2       8'h2A
`define DPS_FN_MANUAL     8'h2B
`define DPS_FN_GO_STEP    8'h2C
`define DPS_FN_HOLD_STEP  8'h2D
`define DPS_FN_STEP_PULSE 8'h14
`define DPS_FN_SEQ_PULSE  8'h15

// ==========================================
// setting limits
`define DPS_STEPS_MIN     4'h1
`define DPS_STEPS_MAX     4'h8
`define DPS_WIN_MIN       8'h02
`define DPS_WIN_MAX       8'hC8
`define DPS_WIN_DEFAULT   8'h0A

// ==========================================
// timing
`define DPS_CLK_MHZ       200
`define DPS_TICK_MS       10
`define DPS_DECI_MS       100
`define DPS_PULSE_MS      100
`define DPS_TICK_CYCLES   (`DPS_TICK_MS * `DPS_CLK_MHZ * 1000)
`define DPS_DECI_TICKS    (`DPS_DECI_MS / `DPS_TICK_MS)
`define DPS_PULSE_TICKS   (`DPS_PULSE_MS / `DPS_TICK_MS)

`endif

// *** core/dps_pkg.sv ***
// types of the drive profile sequencer
// assumes nothing beyond the tool's package support
package dps_pkg;

  // ==========================================
  // sequencer states, one-hot
  typedef enum logic [6:0] {
    DPS_IDLE   = 7'h01,
    DPS_ARM    = 7'h02,
    DPS_LOAD   = 7'h04,
    DPS_FETCH  = 7'h08,
    DPS_RAMP   = 7'h10,
    DPS_DWELL  = 7'h20,
    DPS_WAITGO = 7'h40
  } dps_state_t;

  // ==========================================
  // advance types
  typedef enum logic {
    DPS_FREE_RUN = 1'b0,
    DPS_GATED    = 1'b1
  } dps_adv_t;

endpackage : dps_pkg

// *** core/dps_step_mem.sv ***
// step parameter store: one word per profile and step, registered read
// assumes a single clock; writes come from the configuration side
`timescale 1ns/1ps

module dps_step_mem #(
  parameter int WIDTH = 43,
  parameter int AW    = 4
) (
  input  wire logic             CORE_CLK,
  input  wire logic             WR_EN,
  input  wire logic [AW-1:0]    WR_ADDR,
  input  wire logic [WIDTH-1:0] WR_DATA,
  input  wire logic [AW-1:0]    RD_ADDR,
  output logic      [WIDTH-1:0] RD_DATA
);

  logic [WIDTH-1:0] mem [0:(1<<AW)-1];

  // ==========================================
  // write and registered read, no reset so it maps to ram
  always_ff @(posedge CORE_CLK) begin
    if (WR_EN) begin
      mem[WR_ADDR] <= WR_DATA;
    end
    RD_DATA <= mem[RD_ADDR];
  end

endmodule : dps_step_mem

// *** testbench/dps_seq_properties.sv ***
// port checker for the drive profile sequencer, bound to its top module
// assumes terminal codes and step counts stay steady while a profile runs
`timescale 1ns/1ps
`include "dps_cfg.svh"

module dps_seq_properties
  import dps_pkg::*;
#(
  parameter int NIN         = 8,
  parameter int NOUT        = 3,
  parameter int TICK_CYCLES = 4
) (
  input wire logic              CORE_CLK,
  input wire logic              NRST,
  input wire logic [NIN-1:0]    PIN_IN,
  input wire logic [NIN*8-1:0]  INPUT_PIN_FUNCTION,
  input wire logic [NOUT*8-1:0] OUTPUT_PIN_FUNCTION,
  input wire logic              ADV_TYPE,
  input wire logic [3:0]        STEP_COUNT1,
  input wire logic [3:0]        STEP_COUNT2,
  input wire logic              RUN_CMD,
  input wire logic              USE_MANUAL,
  input wire logic              SEQ_ACTIVE,
  input wire logic              ACTIVE_PROFILE,
  input wire logic [2:0]        STEP_NUM,
  input wire logic              START_CONFLICT,
  input wire logic [NOUT-1:0]   OUT_PIN
);
  // ==========================================
  // terminal and output decode
  logic            manual_on;
  logic            go_on;
  logic            hold_on;
  logic            seq_on;
  logic [2:0]      cnt_last;
  logic [3:0]      cnt_raw;
  logic [31:0]     pls_q;
  logic [NOUT-1:0] step_mask;
  logic [NOUT-1:0] seq_mask;

  // several terminals may share one code, so any of them counts
  always_comb begin
    manual_on = 1'b0;
    go_on     = 1'b0;
    hold_on   = 1'b0;
    for (int i = 0; i < NIN; i++) begin
      manual_on |= PIN_IN[i] && INPUT_PIN_FUNCTION[i*8+:8] == `DPS_FN_MANUAL;
      go_on     |= PIN_IN[i] && INPUT_PIN_FUNCTION[i*8+:8] == `DPS_FN_GO_STEP;
      hold_on   |= PIN_IN[i] && INPUT_PIN_FUNCTION[i*8+:8] == `DPS_FN_HOLD_STEP;
    end
    for (int k = 0; k < NOUT; k++) begin
      step_mask[k] = OUTPUT_PIN_FUNCTION[k*8+:8] == `DPS_FN_STEP_PULSE;
      seq_mask[k]  = OUTPUT_PIN_FUNCTION[k*8+:8] == `DPS_FN_SEQ_PULSE;
    end
  end

  // last step index after clamping the count to one through eight
  assign cnt_raw  = ACTIVE_PROFILE ? STEP_COUNT2 : STEP_COUNT1;
  assign cnt_last = (cnt_raw == 4'h0) ? 3'h0 : (cnt_raw > 4'h8) ? 3'h7 : 3'(cnt_raw - 4'h1);
  assign seq_on   = |(OUT_PIN & seq_mask);

  // length of the sequence pulse in cycles
  always_ff @(posedge CORE_CLK) begin
    if (!NRST || !seq_on)
      pls_q <= 32'h0;
    else
      pls_q <= pls_q + 32'h1;
  end

  // ==========================================
  // properties
  default clocking dps_cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  sequence s_step_adv;
    SEQ_ACTIVE && $past(SEQ_ACTIVE) && STEP_NUM == $past(STEP_NUM) + 3'h1;
  endsequence
  sequence s_go_recent;
    $past(go_on, 1) || $past(go_on, 2) || $past(go_on, 3) || $past(go_on, 4);
  endsequence

  a_step_pulse: assert property (s_step_adv |-> ##[0:2] ((OUT_PIN & step_mask) == step_mask))
    else $error("step pulse missing after a step change");
  a_seq_pulse_last: assert property ($rose(seq_on) |-> SEQ_ACTIVE && STEP_NUM == cnt_last)
    else $error("sequence pulse away from the final step");
  a_seq_pulse_len: assert property ($fell(seq_on) |-> pls_q >= 9 * TICK_CYCLES
    && pls_q <= 11 * TICK_CYCLES) else $error("sequence pulse length off");
  a_hold_freezes: assert property ((!ADV_TYPE && hold_on && SEQ_ACTIVE)[*3] |-> $stable(STEP_NUM))
    else $error("step advanced while held");
  a_gated_go: assert property (s_step_adv ##0 (ADV_TYPE == DPS_GATED) |-> s_go_recent)
    else $error("gated step advanced with no go input");
  a_manual_flag: assert property (manual_on |=> USE_MANUAL)
    else $error("manual flag not raised");
  a_manual_idle: assert property (manual_on[*2] |=> !SEQ_ACTIVE && !RUN_CMD)
    else $error("sequence still running under manual");
  a_run_in_seq: assert property (RUN_CMD |-> SEQ_ACTIVE)
    else $error("run request outside a sequence");
  a_step_range: assert property (RUN_CMD && $past(RUN_CMD) && $stable(ACTIVE_PROFILE)
    |-> STEP_NUM <= cnt_last) else $error("step beyond the step count");
  a_conflict_idle: assert property ($rose(START_CONFLICT) |-> !SEQ_ACTIVE && !RUN_CMD)
    else $error("coincident starts began a profile");
endmodule : dps_seq_properties

bind dps_sequencer dps_seq_properties #(
  .NIN(NIN), .NOUT(NOUT), .TICK_CYCLES(TICK_CYCLES)
) u_props (
  .CORE_CLK(CORE_CLK), .NRST(NRST), .PIN_IN(PIN_IN), .INPUT_PIN_FUNCTION(INPUT_PIN_FUNCTION),
  .OUTPUT_PIN_FUNCTION(OUTPUT_PIN_FUNCTION), .ADV_TYPE(ADV_TYPE), .STEP_COUNT1(STEP_COUNT1),
  .STEP_COUNT2(STEP_COUNT2), .RUN_CMD(RUN_CMD), .USE_MANUAL(USE_MANUAL),
  .SEQ_ACTIVE(SEQ_ACTIVE), .ACTIVE_PROFILE(ACTIVE_PROFILE), .STEP_NUM(STEP_NUM),
  .START_CONFLICT(START_CONFLICT), .OUT_PIN(OUT_PIN)
);

// *** testbench/dps_term_model.sv ***
// terminal side: switches on eight input pins and a motor that coasts to a stop
// assumes level requests from the bench; pins move 1 ns after the clock edge
`timescale 1ns/1ps
`include "dps_cfg.svh"

module dps_term_model (
  input  wire logic        core_clk,
  input  wire logic        seq1_req,
  input  wire logic        seq2_req,
  input  wire logic        manual_req,
  input  wire logic        go_req,
  input  wire logic        hold_req,
  input  wire logic        run_cmd,
  output logic      [7:0]  pin_in,
  output logic      [63:0] input_pin_function,
  output logic             motor_stopped
);
  logic [2:0] spare_q = 3'h5;
  logic [2:0] stop_q  = 3'h0;

  // ==========================================
  // terminals: spare pins toggle so a stray decode shows up
  initial pin_in = 8'h00;
  assign input_pin_function = {16'h0000, `DPS_FN_HOLD_STEP, `DPS_FN_SEQ1, `DPS_FN_MANUAL,
                               `DPS_FN_GO_STEP, `DPS_FN_SEQ2, 8'h00};
  always @(posedge core_clk) begin
    spare_q <= ~spare_q;
    pin_in  <= #1 {spare_q[2:1], hold_req, seq1_req, manual_req, go_req, seq2_req, spare_q[0]};
  end

  // ==========================================
  // motor needs a few cycles to stop after the run request drops
  always @(posedge core_clk) begin
    if (run_cmd)
      stop_q <= 3'h0;
    else if (stop_q != 3'h4)
      stop_q <= stop_q + 3'h1;
  end
  assign motor_stopped = stop_q == 3'h4;
endmodule : dps_term_model

// *** testbench/dps_sequencer_test.sv ***
// self-checking bench for the drive profile sequencer
// assumes the terminal model beside it and a 10 ms tick shortened to 4 cycles
`timescale 1ns/1ps
`include "dps_cfg.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module dps_sequencer_test
  import dps_pkg::*;
;
  logic        core_clk = 1'b0, nrst = 1'b0, adv_type = 1'b0, wr_en = 1'b0, wr_prof = 1'b0;
  logic        wr_fwd = 1'b0, seq1 = 1'b0, seq2 = 1'b0, manual = 1'b0, go = 1'b0, hold = 1'b0;
  logic [2:0]  wr_idx = 3'h0;
  logic [3:0]  cnt2 = 4'h2;
  logic [15:0] wr_freq = 16'h0;
  logic [12:0] wr_ramp = 13'h1, wr_dwell = 13'h1;
  logic [15:0] ef [16];
  logic [12:0] er [16];
  logic        ed [16];
  logic [7:0]  pin_in;
  logic [63:0] pin_fn;
  logic        motor_stopped, run_cmd, dir_fwd, use_manual, seq_active, act_prof, conflict;
  logic [15:0] freq_ref;
  logic [12:0] ramp_time;
  logic [2:0]  step_num, out_pin;
  int          failures = 0, n_tests = 0;

  dps_term_model u_term (.core_clk(core_clk), .seq1_req(seq1), .seq2_req(seq2),
    .manual_req(manual), .go_req(go), .hold_req(hold), .run_cmd(run_cmd), .pin_in(pin_in),
    .input_pin_function(pin_fn), .motor_stopped(motor_stopped));
  dps_sequencer #(.TICK_CYCLES(4)) u_dut (.CORE_CLK(core_clk), .NRST(nrst), .PIN_IN(pin_in),
    .INPUT_PIN_FUNCTION(pin_fn), .ADV_TYPE(adv_type), .COINC_WINDOW(8'h02),
    .OUTPUT_PIN_FUNCTION({8'h00, `DPS_FN_SEQ_PULSE, `DPS_FN_STEP_PULSE}),
    .STEP_COUNT1(4'h3), .STEP_COUNT2(cnt2), .MOTOR_STOPPED(motor_stopped), .STEP_WR_EN(wr_en),
    .STEP_WR_PROFILE(wr_prof), .STEP_WR_INDEX(wr_idx), .STEP_WR_FREQ(wr_freq),
    .STEP_WR_RAMP(wr_ramp), .STEP_WR_DWELL(wr_dwell), .STEP_WR_FWD(wr_fwd),
    .RUN_CMD(run_cmd), .FREQ_REF(freq_ref), .RAMP_TIME(ramp_time), .DIR_FWD(dir_fwd),
    .USE_MANUAL(use_manual), .SEQ_ACTIVE(seq_active), .ACTIVE_PROFILE(act_prof),
    .STEP_NUM(step_num), .START_CONFLICT(conflict), .OUT_PIN(out_pin));

  // ==========================================
  // tasks: every input change lands 1 ns after an edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic wr_step(input logic p, input logic [2:0] i, input logic [15:0] f,
                         input logic [12:0] r, input logic d);
    tick(1);
    {wr_en, wr_prof, wr_idx, wr_freq, wr_ramp, wr_fwd} = {1'b1, p, i, f, r, d};
    {ef[{p, i}], er[{p, i}], ed[{p, i}]} = {f, r, d};
    tick(1);
    wr_en = 1'b0;
  endtask : wr_step

  // step outputs trail the step number by one cycle, so settle first
  task automatic wait_step(input logic p, input logic [2:0] s);
    for (int k = 0; k < 500 && !(run_cmd === 1'b1 && step_num === s); k++) tick(1);
    tick(4);
    `CHK("run", 1'b1, run_cmd)
    `CHK("step", s, step_num)
    `CHK("profile", p, act_prof)
    `CHK("freq", ef[{p, s}], freq_ref)
    `CHK("ramp", er[{p, s}], ramp_time)
    `CHK("dir", ed[{p, s}], dir_fwd)
  endtask : wait_step

  task automatic wait_idle();
    for (int k = 0; k < 400 && seq_active !== 1'b0; k++) tick(1);
    `CHK("idle", 1'b0, seq_active)
  endtask : wait_idle

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  // ==========================================
  // clock, hang guard and the test sequence
  initial forever #2.5 core_clk = ~core_clk;

  initial begin
    repeat (8000) @(posedge core_clk);
    failures++;
    close_out();
  end

  initial begin
    tick(4);
    nrst = 1'b1;
    `CHK("reset", 19'h00003, {run_cmd, seq_active, out_pin, ramp_time, dir_fwd})
    for (int i = 0; i < 4; i++) wr_step(1'b0, 3'(i), 16'(i * 256 + 256), 13'(1 + i % 2), i[0]);
    wr_step(1'b1, 3'h0, 16'h2000, 13'h0001, 1'b0);
    wr_step(1'b1, 3'h1, 16'h2001, 13'h0001, 1'b1);
    // free run: all three steps unattended, pulses, then idle
    seq1 = 1'b1;
    wait_step(1'b0, 3'h0);
    seq1 = 1'b0;
    wait_step(1'b0, 3'h1);
    `CHK("step pulse", 1'b1, out_pin[0])
    wait_step(1'b0, 3'h2);
    `CHK("seq pulse", 3'h3, out_pin)
    wait_idle();
    `CHK("end idle", 2'h0, {seq_active, run_cmd})
    // manual terminal takes over a running profile
    seq1 = 1'b1;
    wait_step(1'b0, 3'h0);
    manual = 1'b1;
    tick(4);
    `CHK("manual", 3'h4, {use_manual, seq_active, run_cmd})
    {manual, seq1} = 2'h0;
    tick(4);
    // both starts inside the window are refused
    seq1 = 1'b1;
    tick(2);
    seq2 = 1'b1;
    tick(40);
    `CHK("conflict", 2'h2, {conflict, seq_active})
    {seq1, seq2} = 2'h0;
    // let the low level reach the core, or the next start shows no rising edge
    tick(4);
    // profile two under hold stays on its first step
    hold = 1'b1;
    seq2 = 1'b1;
    wait_step(1'b1, 3'h0);
    seq2 = 1'b0;
    tick(300);
    `CHK("held", 4'h0, {step_num, conflict})
    hold = 1'b0;
    wait_step(1'b1, 3'h1);
    wait_idle();
    // gated type: one step per go while stopped, idle once starts drop
    adv_type = DPS_GATED;
    seq1 = 1'b1;
    wait_step(1'b0, 3'h0);
    tick(250);
    `CHK("gated wait", 4'h0, {step_num, run_cmd})
    go = 1'b1;
    tick(3);
    go = 1'b0;
    wait_step(1'b0, 3'h1);
    seq1 = 1'b0;
    wait_idle();
    `CHK("gated end", 1'b0, seq_active)
    // a zero step count is taken as one: single step, sequence pulse only
    adv_type = DPS_FREE_RUN;
    cnt2 = 4'h0;
    seq2 = 1'b1;
    wait_step(1'b1, 3'h0);
    `CHK("one step pulse", 3'h2, out_pin)
    seq2 = 1'b0;
    wait_idle();
    `CHK("one step end", 2'h0, {seq_active, run_cmd})
    close_out();
  end
endmodule : dps_sequencer_test
